// *** common/pcr_map.svh ***
// Offsets, field positions, reset values and fixed patterns of the configuration space
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// Byte offsets of the implemented words
`define PCR_OFF_IDENT    8'h00
`define PCR_OFF_CMDSTS   8'h04
`define PCR_OFF_REVISION 8'h08
`define PCR_OFF_LATENCY  8'h0C
`define PCR_OFF_IO_BASE  8'h10
`define PCR_OFF_MEM_BASE 8'h14
`define PCR_OFF_SUBSYS   8'h2C
`define PCR_OFF_ROM_BASE 8'h30
`define PCR_OFF_CAP_PTR  8'h34
`define PCR_OFF_INT_SEL  8'h3C
`define PCR_OFF_PM_CAP   8'h40
`define PCR_OFF_PM_CSR   8'h44

// Command bit positions and the set of bits that software may change
`define PCR_CMD_IO       0
`define PCR_CMD_MEM      1
`define PCR_CMD_BM       2
`define PCR_CMD_PERR     6
`define PCR_CMD_SERR     8
`define PCR_CMD_FBB      9
`define PCR_CMD_WMASK    32'h0000_0347

// Status flag index inside the six-bit flag vector
`define PCR_FLG_DPAR     0
`define PCR_FLG_TABT_TX  1
`define PCR_FLG_TABT_RX  2
`define PCR_FLG_MABT_RX  3
`define PCR_FLG_SERR_TX  4
`define PCR_FLG_PAR_DET  5
`define PCR_FLG_COUNT    6

// Status bit positions of each flag in the command/status word
`define PCR_POS_DPAR     24
`define PCR_POS_TABT_TX  27
`define PCR_POS_TABT_RX  28
`define PCR_POS_MABT_RX  29
`define PCR_POS_SERR_TX  30
`define PCR_POS_PAR_DET  31

// Fixed status pattern: select timing 01 and back-to-back capable
`define PCR_SEL_TIMING   2'h1
`define PCR_STS_FIXED    32'h0280_0000

// Hardware reset values
`define PCR_RST_WORD     32'h0000_0000
`define PCR_RST_CMD      16'h0000
`define PCR_RST_FLAGS    6'h00

// Defaults of the read-only words, arbitrary values
`define PCR_DEF_DEVICE   16'h0A5C
`define PCR_DEF_VENDOR   16'h1F3E
`define PCR_DEF_REVISION 32'h0200_0000
`define PCR_DEF_LATENCY  32'h0000_0000
`define PCR_DEF_SUBSYS   32'h0000_0000
`define PCR_DEF_CAP_PTR  32'h0000_0040
`define PCR_DEF_PM_CAP   32'h0002_0001

`endif

// *** common/pcr_pkg.sv ***
// Types shared by the configuration space modules
package pcr_pkg;
	typedef logic [31:0] pcr_word_t;
	typedef logic [7:0]  pcr_addr_t;
	typedef logic [5:0]  pcr_flags_t;
endpackage : pcr_pkg

// *** common/pcr_cfg_if.sv ***
// Carrier between the configuration core, the flag store and the read stage
`timescale 1ns/1ps
interface pcr_cfg_if;
	import pcr_pkg::*;
	logic       clr_stb;
	pcr_flags_t clr_mask;
	pcr_flags_t set_evt;
	pcr_flags_t flags;
	logic       rd_req;
	pcr_word_t  rd_word;
	pcr_word_t  rd_data;
	logic       rd_valid;
	modport core      (output clr_stb, clr_mask, set_evt, rd_req, rd_word,
	                   input flags, rd_data, rd_valid);
	modport flag_end  (input clr_stb, clr_mask, set_evt, output flags);
	modport read_end  (input rd_req, rd_word, output rd_data, rd_valid);
endinterface : pcr_cfg_if

// *** rtl/pcr_status_flags.sv ***
// Sticky status flags, set by events and cleared by writing one
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_status_flags
	import pcr_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	pcr_cfg_if.flag_end bus
);
	pcr_flags_t next_flags;
	pcr_flags_t clr_hit;

	// A set in the clearing cycle wins, so no event is lost
	assign clr_hit    = bus.clr_mask & {`PCR_FLG_COUNT{bus.clr_stb}};
	assign next_flags = bus.set_evt | (bus.flags & ~clr_hit);

	// Only the hardware reset touches the flags
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus.flags <= `PCR_RST_FLAGS;
		end else begin
			bus.flags <= next_flags;
		end
	end

	AST_SET_WINS: assert property (@(posedge clock) disable iff (!rst_n)
		bus.set_evt[`PCR_FLG_MABT_RX] && bus.clr_stb && bus.clr_mask[`PCR_FLG_MABT_RX]
		|=> bus.flags[`PCR_FLG_MABT_RX])
		else $error("Flag lost when set and clear met");

	AST_CLEAR_ONE: assert property (@(posedge clock) disable iff (!rst_n)
		bus.clr_stb && bus.clr_mask[`PCR_FLG_PAR_DET] && !bus.set_evt[`PCR_FLG_PAR_DET]
		|=> !bus.flags[`PCR_FLG_PAR_DET] ##1 bus.flags[`PCR_FLG_PAR_DET]
		== $past(bus.set_evt[`PCR_FLG_PAR_DET]))
		else $error("Flag not cleared by a written one");
endmodule : pcr_status_flags

// *** rtl/pcr_read_stage.sv ***
// Registered read data and its one-cycle valid strobe
`timescale 1ns/1ps
module pcr_read_stage
	import pcr_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	pcr_cfg_if.read_end bus
);
	// Data holds between reads so the bus side may sample late
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus.rd_data  <= 32'h0000_0000;
			bus.rd_valid <= 1'b0;
		end else begin
			bus.rd_valid <= bus.rd_req;
			if (bus.rd_req) begin
				bus.rd_data <= bus.rd_word;
			end
		end
	end

	AST_READ_LATENCY: assert property (@(posedge clock) disable iff (!rst_n)
		bus.rd_req |=> bus.rd_valid && bus.rd_data == $past(bus.rd_word))
		else $error("Read answer late or wrong");
endmodule : pcr_read_stage

// *** rtl/pcr_config_space.sv ***
// Configuration register space: decode, command and address registers, read selection
// Behaviour
// - Offer a standard configuration space so firmware assigns resources without jumpers.
// - A software reset leaves every configuration register unchanged.
// - Hardware reset returns every configuration register to its reset value.
// - Unimplemented locations ignore writes and read as zero.
// - Decode offsets 00h to 44h into twelve words; reserved spans read zero.
// - Word 00h is read-only: device identifier high, vendor identifier low.
// - Upper status flags clear where a written word holds one, only when its top byte lane is enabled.
// - Lower sixteen bits hold writable command controls enabling the device.
// - Select timing reads 01 at bits 26-25; bit 23 always reads one.
`timescale 1ns/1ps
`include "pcr_map.svh"
module pcr_config_space
	import pcr_pkg::*;
#(
	parameter logic [15:0] DEVICE_ID     = `PCR_DEF_DEVICE,   // Arbitrary value
	parameter logic [15:0] VENDOR_ID     = `PCR_DEF_VENDOR,   // Arbitrary value
	parameter pcr_word_t   REVISION_WORD = `PCR_DEF_REVISION,
	parameter pcr_word_t   LATENCY_WORD  = `PCR_DEF_LATENCY,
	parameter pcr_word_t   SUBSYS_WORD   = `PCR_DEF_SUBSYS,   // Arbitrary value
	parameter pcr_word_t   CAP_PTR_WORD  = `PCR_DEF_CAP_PTR,
	parameter pcr_word_t   PM_CAP_WORD   = `PCR_DEF_PM_CAP
)(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       soft_reset,
	input  wire logic       cfg_req,
	input  wire logic       cfg_write,
	input  wire pcr_addr_t  cfg_addr,
	input  wire logic [3:0] cfg_byte_en,
	input  wire pcr_word_t  cfg_wdata,
	output pcr_word_t       cfg_rdata,
	output logic            cfg_rvalid,
	input  wire pcr_flags_t error_events,
	output pcr_flags_t      status_flags,
	output logic            io_space_en,
	output logic            mem_space_en,
	output logic            bus_master_en,
	output logic            parity_resp_en,
	output logic            serr_en,
	output logic            back_to_back_en,
	output pcr_word_t       io_base,
	output pcr_word_t       mem_base,
	output pcr_word_t       rom_base,
	output pcr_word_t       int_select,
	output pcr_word_t       pm_control
);
	pcr_cfg_if bus ();

	logic [15:0] command;
	logic [15:0] next_command;
	pcr_word_t   next_cmd_word;
	pcr_word_t   next_io_base;
	pcr_word_t   next_mem_base;
	pcr_word_t   next_rom_base;
	pcr_word_t   next_int_select;
	pcr_word_t   next_pm_control;

	// Bit positions of the flags inside the command/status word
	localparam int unsigned FLAG_POS [`PCR_FLG_COUNT] = '{
		`PCR_POS_DPAR, `PCR_POS_TABT_TX, `PCR_POS_TABT_RX,
		`PCR_POS_MABT_RX, `PCR_POS_SERR_TX, `PCR_POS_PAR_DET};

	// Merge written bytes into a word, touching only bits in the mask
	function automatic pcr_word_t merge_bytes(input pcr_word_t old_word,
		input pcr_word_t new_word, input logic [3:0] lanes, input pcr_word_t mask);
		pcr_word_t lane_mask;
		lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}} & mask;
		return (old_word & ~lane_mask) | (new_word & lane_mask);
	endfunction : merge_bytes

	// Address decode on whole words; the two low address bits are ignored
	wire pcr_addr_t word_addr    = {cfg_addr[7:2], 2'b00};
	wire            wr_go        = cfg_req && cfg_write;
	wire            rd_go        = cfg_req && !cfg_write;
	wire            hit_ident    = word_addr == `PCR_OFF_IDENT;
	wire            hit_cmdsts   = word_addr == `PCR_OFF_CMDSTS;
	wire            hit_revision = word_addr == `PCR_OFF_REVISION;
	wire            hit_latency  = word_addr == `PCR_OFF_LATENCY;
	wire            hit_io_base  = word_addr == `PCR_OFF_IO_BASE;
	wire            hit_mem_base = word_addr == `PCR_OFF_MEM_BASE;
	wire            hit_subsys   = word_addr == `PCR_OFF_SUBSYS;
	wire            hit_rom_base = word_addr == `PCR_OFF_ROM_BASE;
	wire            hit_cap_ptr  = word_addr == `PCR_OFF_CAP_PTR;
	wire            hit_int_sel  = word_addr == `PCR_OFF_INT_SEL;
	wire            hit_pm_cap   = word_addr == `PCR_OFF_PM_CAP;
	wire            hit_pm_csr   = word_addr == `PCR_OFF_PM_CSR;
	wire            hit_any      = |{hit_ident, hit_cmdsts, hit_revision, hit_latency,
	                                 hit_io_base, hit_mem_base, hit_subsys, hit_rom_base,
	                                 hit_cap_ptr, hit_int_sel, hit_pm_cap, hit_pm_csr};

	// Fixed identity word; no write path exists for it
	wire pcr_word_t ident_word = {DEVICE_ID, VENDOR_ID};

	// Status half: live flags plus the fixed timing and capability bits
	wire pcr_word_t status_word = {bus.flags[`PCR_FLG_PAR_DET], bus.flags[`PCR_FLG_SERR_TX],
	                               bus.flags[`PCR_FLG_MABT_RX], bus.flags[`PCR_FLG_TABT_RX],
	                               bus.flags[`PCR_FLG_TABT_TX], 2'b00,
	                               bus.flags[`PCR_FLG_DPAR], 24'h00_0000}
	                              | `PCR_STS_FIXED;
	wire pcr_word_t cmdsts_word = status_word | {16'h0000, command};

	// Read selection as an and-or tree; a miss yields zero without a default arm
	assign bus.rd_word = ({32{hit_ident}}    & ident_word)
	                   | ({32{hit_cmdsts}}   & cmdsts_word)
	                   | ({32{hit_revision}} & REVISION_WORD)
	                   | ({32{hit_latency}}  & LATENCY_WORD)
	                   | ({32{hit_io_base}}  & io_base)
	                   | ({32{hit_mem_base}} & mem_base)
	                   | ({32{hit_subsys}}   & SUBSYS_WORD)
	                   | ({32{hit_rom_base}} & rom_base)
	                   | ({32{hit_cap_ptr}}  & CAP_PTR_WORD)
	                   | ({32{hit_int_sel}}  & int_select)
	                   | ({32{hit_pm_cap}}   & PM_CAP_WORD)
	                   | ({32{hit_pm_csr}}   & pm_control);
	assign bus.rd_req  = rd_go;
	assign cfg_rdata   = bus.rd_data;
	assign cfg_rvalid  = bus.rd_valid;

	// Clearing needs the top byte lane, since every flag sits in it
	assign bus.clr_stb = wr_go && hit_cmdsts && cfg_byte_en[3];
	generate
		for (genvar i = 0; i < `PCR_FLG_COUNT; i++) begin : g_clr
			assign bus.clr_mask[i] = cfg_wdata[FLAG_POS[i]];
		end
	endgenerate

	// Event gating: data parity needs parity response, system error needs both enables
	assign bus.set_evt[`PCR_FLG_DPAR]    = error_events[`PCR_FLG_DPAR] && parity_resp_en;
	assign bus.set_evt[`PCR_FLG_TABT_TX] = error_events[`PCR_FLG_TABT_TX];
	assign bus.set_evt[`PCR_FLG_TABT_RX] = error_events[`PCR_FLG_TABT_RX];
	assign bus.set_evt[`PCR_FLG_MABT_RX] = error_events[`PCR_FLG_MABT_RX];
	assign bus.set_evt[`PCR_FLG_SERR_TX] = error_events[`PCR_FLG_SERR_TX]
	                                       && serr_en && parity_resp_en;
	assign bus.set_evt[`PCR_FLG_PAR_DET] = error_events[`PCR_FLG_PAR_DET];
	assign status_flags = bus.flags;

	// Next values; only implemented command bits take writes
	// Upper half of the merged word is status, which is never stored here
	assign next_cmd_word   = merge_bytes({16'h0000, command}, cfg_wdata, cfg_byte_en,
	                                     `PCR_CMD_WMASK);
	assign next_command    = next_cmd_word[15:0];
	assign next_io_base    = merge_bytes(io_base, cfg_wdata, cfg_byte_en, 32'hFFFF_FFFF);
	assign next_mem_base   = merge_bytes(mem_base, cfg_wdata, cfg_byte_en, 32'hFFFF_FFFF);
	assign next_rom_base   = merge_bytes(rom_base, cfg_wdata, cfg_byte_en, 32'hFFFF_FFFF);
	assign next_int_select = merge_bytes(int_select, cfg_wdata, cfg_byte_en, 32'hFFFF_FFFF);
	assign next_pm_control = merge_bytes(pm_control, cfg_wdata, cfg_byte_en, 32'hFFFF_FFFF);

	// Command controls; soft_reset is deliberately not a term here
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			command <= `PCR_RST_CMD;
		end else if (wr_go && hit_cmdsts) begin
			command <= next_command;
		end
	end

	// Base address registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			io_base  <= `PCR_RST_WORD;
			mem_base <= `PCR_RST_WORD;
		end else begin
			io_base  <= (wr_go && hit_io_base)  ? next_io_base  : io_base;
			mem_base <= (wr_go && hit_mem_base) ? next_mem_base : mem_base;
		end
	end

	// Boot memory base and interrupt selection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rom_base   <= `PCR_RST_WORD;
			int_select <= `PCR_RST_WORD;
		end else begin
			rom_base   <= (wr_go && hit_rom_base) ? next_rom_base   : rom_base;
			int_select <= (wr_go && hit_int_sel)  ? next_int_select : int_select;
		end
	end

	// Power management control word
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pm_control <= `PCR_RST_WORD;
		end else if (wr_go && hit_pm_csr) begin
			pm_control <= next_pm_control;
		end
	end

	// Command bits steer the rest of the device
	assign io_space_en     = command[`PCR_CMD_IO];
	assign mem_space_en    = command[`PCR_CMD_MEM];
	assign bus_master_en   = command[`PCR_CMD_BM];
	assign parity_resp_en  = command[`PCR_CMD_PERR];
	assign serr_en         = command[`PCR_CMD_SERR];
	assign back_to_back_en = command[`PCR_CMD_FBB];

	pcr_status_flags u_flags (
		.clock (clock),
		.rst_n (rst_n),
		.bus   (bus.flag_end)
	);

	pcr_read_stage u_read (
		.clock (clock),
		.rst_n (rst_n),
		.bus   (bus.read_end)
	);

	AST_IDENT_READ: assert property (@(posedge clock) disable iff (!rst_n)
		rd_go && hit_ident |=> cfg_rvalid && cfg_rdata == {DEVICE_ID, VENDOR_ID})
		else $error("Identity word read wrong");

	AST_UNMAPPED_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		rd_go && !hit_any |=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
		else $error("Unmapped read not zero");

	AST_RESERVED_38: assert property (@(posedge clock) disable iff (!rst_n)
		rd_go && cfg_addr[7:2] == 6'h0E |=> cfg_rdata == 32'h0000_0000)
		else $error("Reserved word at 38h not zero");

	AST_FIXED_STATUS: assert property (@(posedge clock) disable iff (!rst_n)
		rd_go && hit_cmdsts |=> cfg_rdata[26:25] == `PCR_SEL_TIMING && cfg_rdata[23]
		&& cfg_rdata[22:16] == 7'h00)
		else $error("Fixed status bits wrong");

	AST_CMD_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		wr_go && hit_cmdsts && cfg_byte_en[0] |=> bus_master_en == $past(cfg_wdata[2])
		&& command[5:3] == 3'h0)
		else $error("Command byte not written as masked");

	AST_STATUS_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		wr_go && hit_cmdsts && cfg_byte_en[3] && cfg_wdata[29]
		&& !error_events[`PCR_FLG_MABT_RX] |=> !status_flags[`PCR_FLG_MABT_RX])
		else $error("Written one did not clear flag");

	AST_SOFT_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
		soft_reset && !wr_go |=> $stable(command) && $stable(io_base) && $stable(pm_control))
		else $error("Software reset changed a register");

	AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		wr_go && !hit_any |=> $stable(command) && $stable(mem_base) && $stable(rom_base)
		&& $stable(int_select))
		else $error("Unmapped write changed a register");

	AST_SERR_GATED: assert property (@(posedge clock) disable iff (!rst_n)
		!status_flags[`PCR_FLG_SERR_TX] && !(serr_en && parity_resp_en)
		|=> !status_flags[`PCR_FLG_SERR_TX])
		else $error("System error flag set while disabled");

	AST_EVENT_SETS: assert property (@(posedge clock) disable iff (!rst_n)
		error_events[`PCR_FLG_TABT_TX] |=> status_flags[`PCR_FLG_TABT_TX]
		##1 (status_flags[`PCR_FLG_TABT_TX] || $past(bus.clr_stb)))
		else $error("Sent target abort flag not set");

	// Read strobe lasts one cycle; data holds so a slow host still sees it
	AST_RVALID_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
		!rd_go |=> !cfg_rvalid)
		else $error("Read strobe without a read");

	AST_RDATA_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
		!rd_go |=> $stable(cfg_rdata))
		else $error("Read data moved without a read");

	// Byte lanes gate the writable words
	AST_IO_LANE_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		wr_go && hit_io_base && cfg_byte_en[0]
		|=> io_base[7:0] == $past(cfg_wdata[7:0]))
		else $error("Base byte not written");

	AST_MEM_LANE_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
		wr_go && hit_mem_base && !cfg_byte_en[3]
		|=> mem_base[31:24] == $past(mem_base[31:24]))
		else $error("Disabled byte lane written");

	AST_ROM_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
		!(wr_go && hit_rom_base) |=> $stable(rom_base))
		else $error("Boot memory base changed without a write");

	// Command half moves only on its own write, and only in implemented bits
	AST_CMD_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
		!(wr_go && hit_cmdsts) |=> $stable(command))
		else $error("Command changed without a write");

	AST_CMD_RESERVED: assert property (@(posedge clock) disable iff (!rst_n)
		({16'h0000, command} & ~`PCR_CMD_WMASK) == 32'h0000_0000)
		else $error("Unimplemented command bit set");

	// A flag stays until a written one clears it
	AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
		status_flags[`PCR_FLG_TABT_RX] && !(wr_go && hit_cmdsts && cfg_byte_en[3])
		|=> status_flags[`PCR_FLG_TABT_RX])
		else $error("Flag dropped without a clearing write");

	AST_DPAR_GATED: assert property (@(posedge clock) disable iff (!rst_n)
		!status_flags[`PCR_FLG_DPAR] && !parity_resp_en
		|=> !status_flags[`PCR_FLG_DPAR])
		else $error("Data parity flag set while parity response off");

	AST_PAR_DET_SETS: assert property (@(posedge clock) disable iff (!rst_n)
		error_events[`PCR_FLG_PAR_DET] |=> status_flags[`PCR_FLG_PAR_DET])
		else $error("Parity detected flag not set");

	AST_SOFT_KEEP_WORDS: assert property (@(posedge clock) disable iff (!rst_n)
		soft_reset && !wr_go |=> $stable(mem_base) && $stable(rom_base)
		&& $stable(int_select))
		else $error("Software reset changed a base word");
endmodule : pcr_config_space

// *** verification/pcr_host_model.sv ***
// Host bridge model issuing configuration reads and writes
`timescale 1ns/1ps
module pcr_host_model
	import pcr_pkg::*;
(
	input  wire logic      clock,
	output logic           cfg_req,
	output logic           cfg_write,
	output pcr_addr_t      cfg_addr,
	output logic [3:0]     cfg_byte_en,
	output pcr_word_t      cfg_wdata,
	input  wire pcr_word_t cfg_rdata,
	input  wire logic      cfg_rvalid
);
	initial begin
		cfg_req     = 1'b0;
		cfg_write   = 1'b0;
		cfg_addr    = 8'h00;
		cfg_byte_en = 4'h0;
		cfg_wdata   = 32'h0000_0000;
	end

	// One access per call, changed on the falling edge; idle lines carry the
	// inverse of the last value so stale data never passes for a request
	task automatic access(input logic wr, input pcr_addr_t a, input logic [3:0] be,
		input pcr_word_t d, output pcr_word_t q, output logic v);
		@(negedge clock);
		cfg_req     = 1'b1;
		cfg_write   = wr;
		cfg_addr    = a;
		cfg_byte_en = be;
		cfg_wdata   = d;
		@(negedge clock);
		q           = cfg_rdata;
		v           = cfg_rvalid;
		cfg_req     = 1'b0;
		cfg_write   = ~wr;
		cfg_addr    = ~a;
		cfg_byte_en = ~be;
		cfg_wdata   = ~d;
	endtask : access

	// Flags are cleared by writing ones into the top byte only
	task automatic clear_flags(input pcr_word_t m);
		pcr_word_t q;
		logic      v;
		access(1'b1, 8'h04, 4'b1000, m, q, v);
	endtask : clear_flags
endmodule : pcr_host_model

// *** verification/test_pcr_config_space.sv ***
// Self-checking bench of the configuration register space
`timescale 1ns/1ps
`include "pcr_map.svh"
module test_pcr_config_space
	import pcr_pkg::*;
;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic       soft_reset = 1'b0;
	pcr_flags_t error_events = 6'h00;
	logic       cfg_req;
	logic       cfg_write;
	pcr_addr_t  cfg_addr;
	logic [3:0] cfg_byte_en;
	pcr_word_t  cfg_wdata;
	pcr_word_t  cfg_rdata;
	logic       cfg_rvalid;
	pcr_flags_t status_flags;
	logic [5:0] enables;
	pcr_word_t  io_base;
	pcr_word_t  mem_base;
	pcr_word_t  rom_base;
	pcr_word_t  int_select;
	pcr_word_t  pm_control;
	int         bad_count = 0;
	int         compares = 0;
	pcr_addr_t  rw_offs [5] = '{`PCR_OFF_IO_BASE, `PCR_OFF_MEM_BASE, `PCR_OFF_ROM_BASE,
		`PCR_OFF_INT_SEL, `PCR_OFF_PM_CSR};
	pcr_addr_t  rsv_offs [8] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h38, 8'h48, 8'hFC};
	pcr_word_t  ident = {`PCR_DEF_DEVICE, `PCR_DEF_VENDOR};

	always #2.5 clock = ~clock;

	pcr_config_space u_dut (
		.clock(clock), .rst_n(rst_n), .soft_reset(soft_reset), .cfg_req(cfg_req),
		.cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.error_events(error_events), .status_flags(status_flags),
		.io_space_en(enables[0]), .mem_space_en(enables[1]), .bus_master_en(enables[2]),
		.parity_resp_en(enables[3]), .serr_en(enables[4]), .back_to_back_en(enables[5]),
		.io_base(io_base), .mem_base(mem_base), .rom_base(rom_base),
		.int_select(int_select), .pm_control(pm_control));

	pcr_host_model u_host (
		.clock(clock), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid));

	task automatic chk(input string n, input pcr_word_t e, input pcr_word_t g);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : chk

	// A read must answer with the valid pulse one edge after it is taken
	task automatic rd(input pcr_addr_t a, input pcr_word_t e);
		pcr_word_t q;
		logic      v;
		u_host.access(1'b0, a, 4'h0, 32'h0000_0000, q, v);
		chk($sformatf("read %h", a), e, q);
		chk("read valid", 32'h0000_0001, {31'h0, v});
	endtask : rd

	task automatic wr(input pcr_addr_t a, input logic [3:0] be, input pcr_word_t d);
		pcr_word_t q;
		logic      v;
		u_host.access(1'b1, a, be, d, q, v);
	endtask : wr

	// One event pulse, seen in the flags one edge later
	task automatic pulse(input pcr_flags_t m, input pcr_flags_t e);
		@(negedge clock);
		error_events = m;
		@(negedge clock);
		error_events = 6'h00;
		chk("status flags", {26'h0, e}, {26'h0, status_flags});
	endtask : pulse

	task automatic t_reset_values;
		rd(`PCR_OFF_IDENT, ident);
		rd(`PCR_OFF_CMDSTS, `PCR_STS_FIXED);
		rd(`PCR_OFF_REVISION, `PCR_DEF_REVISION);
		rd(`PCR_OFF_LATENCY, `PCR_DEF_LATENCY);
		rd(`PCR_OFF_SUBSYS, `PCR_DEF_SUBSYS);
		rd(`PCR_OFF_CAP_PTR, `PCR_DEF_CAP_PTR);
		rd(`PCR_OFF_PM_CAP, `PCR_DEF_PM_CAP);
		foreach (rw_offs[i]) rd(rw_offs[i], `PCR_RST_WORD);
		chk("enables", 32'h0, {26'h0, enables});
	endtask : t_reset_values

	// Partial lanes prove byte enables gate each writable word
	task automatic t_rw_words;
		foreach (rw_offs[i]) wr(rw_offs[i], 4'b0101, 32'hA5A5_A5A5 ^ i);
		foreach (rw_offs[i]) rd(rw_offs[i], (32'hA5A5_A5A5 ^ i) & 32'h00FF_00FF);
		chk("io base", 32'h00A5_00A5, io_base);
		chk("mem base", 32'h00A5_00A4, mem_base);
		chk("rom base", 32'h00A5_00A7, rom_base);
		chk("int select", 32'h00A5_00A6, int_select);
		chk("pm control", 32'h00A5_00A1, pm_control);
	endtask : t_rw_words

	task automatic t_protected;
		wr(`PCR_OFF_IDENT, 4'hF, 32'hFFFF_FFFF);
		rd(`PCR_OFF_IDENT, ident);
		rd(8'h02, ident);
		foreach (rsv_offs[i]) wr(rsv_offs[i], 4'hF, 32'hFFFF_FFFF);
		foreach (rsv_offs[i]) rd(rsv_offs[i], 32'h0000_0000);
	endtask : t_protected

	task automatic t_command;
		wr(`PCR_OFF_CMDSTS, 4'b0011, 32'hFFFF_FFFF);
		rd(`PCR_OFF_CMDSTS, 32'h0280_0347);
		chk("enables", 32'h3F, {26'h0, enables});
	endtask : t_command

	// All six flags set, then two cleared, then the rest
	task automatic t_flags;
		for (int i = 0; i < 6; i++) pulse(6'h01 << i, (6'h02 << i) - 6'h01);
		rd(`PCR_OFF_CMDSTS, 32'hFB80_0347);
		u_host.clear_flags(32'h2100_0000);
		rd(`PCR_OFF_CMDSTS, 32'hDA80_0347);
		// Event and clear of one flag in the same cycle: the event wins
		fork
			u_host.clear_flags(32'h2000_0000);
			begin
				@(negedge clock);
				error_events = 6'h08;
				@(negedge clock);
				error_events = 6'h00;
			end
		join
		rd(`PCR_OFF_CMDSTS, 32'hFA80_0347);
		u_host.clear_flags(32'hFFFF_FFFF);
		rd(`PCR_OFF_CMDSTS, 32'h0280_0347);
		wr(`PCR_OFF_CMDSTS, 4'b0011, 32'h0000_0000);
		pulse(6'h11, 6'h00);
	endtask : t_flags

	task automatic t_soft_reset;
		wr(`PCR_OFF_CMDSTS, 4'b0011, 32'h0000_0005);
		@(negedge clock);
		soft_reset = 1'b1;
		repeat (3) @(negedge clock);
		soft_reset = 1'b0;
		rd(`PCR_OFF_CMDSTS, 32'h0280_0005);
		foreach (rw_offs[i]) rd(rw_offs[i], (32'hA5A5_A5A5 ^ i) & 32'h00FF_00FF);
	endtask : t_soft_reset

	// A second hardware reset in mid-run must clear what was written
	task automatic t_hw_reset;
		pulse(6'h02, 6'h02);
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		chk("flags after reset", 32'h0, {26'h0, status_flags});
		chk("io base after reset", 32'h0, io_base);
		chk("pm control after reset", 32'h0, pm_control);
		rd(`PCR_OFF_CMDSTS, `PCR_STS_FIXED);
		foreach (rw_offs[i]) rd(rw_offs[i], `PCR_RST_WORD);
	endtask : t_hw_reset

	task automatic close_out;
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	// Well above the under two hundred cycles the scenarios need
	initial begin
		#20000;
		bad_count++;
		close_out();
	end

	initial begin
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		t_reset_values();
		t_rw_words();
		t_protected();
		t_command();
		t_flags();
		t_soft_reset();
		t_hw_reset();
		close_out();
	end
endmodule : test_pcr_config_space
